// File: hdl/fpdc_pkg.sv
// constants, field layout and carrier types of the two-fan duty controller
package fpdc_pkg;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] OFS_GLOBAL_CONFIG = 8'h02;
   localparam logic [7:0] OFS_START_DUTY = 8'h08;
   localparam logic [7:0] OFS_FAN1_CEIL = 8'h09;
   localparam logic [7:0] OFS_FAN2_CEIL = 8'h0A;
   localparam logic [7:0] OFS_FAN1_GOAL = 8'h0B;
   localparam logic [7:0] OFS_FAN2_GOAL = 8'h0C;
   localparam logic [7:0] OFS_FAN1_PRES = 8'h0D;
   localparam logic [7:0] OFS_FAN2_PRES = 8'h0E;
   localparam logic [7:0] OFS_CHAN1_START_T = 8'h0F;
   localparam logic [7:0] OFS_CHAN2_START_T = 8'h10;
   localparam logic [7:0] OFS_SETUP = 8'h11;
   localparam logic [7:0] OFS_RATE = 8'h12;
   localparam logic [7:0] OFS_STEP = 8'h13;

   // ****************************************
   // field positions
   // ****************************************
   localparam int GC_STANDBY = 7;
   localparam int GC_SOFT_RST = 6;
   localparam int GC_TMO_OFF = 5;
   localparam int GC_FAN1_POL = 4;
   localparam int GC_FAN2_POL = 3;
   localparam int GC_FLOOR = 2;
   localparam int GC_CH2_DIE = 1;
   localparam int GC_KICK_OFF = 0;
   localparam int FS_HYST = 7;
   localparam int FS_TSTEP = 6;
   localparam int FS_F1_C1 = 5;
   localparam int FS_F1_C2 = 4;
   localparam int FS_F2_C1 = 3;
   localparam int FS_F2_C2 = 2;
   localparam int RATE_F1_LSB = 5;
   localparam int RATE_F2_LSB = 2;
   localparam int STEP_C1_LSB = 4;
   localparam int STEP_C2_LSB = 0;

   // ****************************************
   // reset values and duty figures
   // ****************************************
   localparam logic [7:0] RST_GLOBAL = 8'h18;
   localparam logic [7:0] RST_CEIL = 8'hF0;
   localparam logic [7:0] RST_GOAL = 8'h00;
   localparam logic [7:0] RST_PRES = 8'h00;
   localparam logic [7:0] RST_START_T = 8'h00;
   localparam logic [7:0] RST_SETUP = 8'h00;
   localparam logic [7:0] RST_RATE = 8'hB4;
   localparam logic [7:0] RST_STEP = 8'h55;
   localparam logic [7:0] RST_START_DUTY = 8'h60;
   localparam logic [7:0] DUTY_FULL = 8'hF0;
   localparam logic [7:0] DUTY_CEIL_MIN = 8'h02;
   localparam logic [7:0] RAMP_STEP = 8'h02;
   localparam logic [7:0] HYST_LO = 8'h05;
   localparam logic [7:0] HYST_HI = 8'h0A;
   localparam logic [3:0] STEP_CODE_TOP = 4'hF;
   localparam logic [4:0] STEP_TOP_DUTY = 5'h1F;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_HZ = 10_000_000;
   localparam int RAMP_TICK_US = 62500;
   localparam int RAMP_TICK_CYCLES = RAMP_TICK_US * (CLK_HZ / 1_000_000);
   localparam int SPIN_TICKS = 32;
   localparam int SMBUS_TMO_US = 25000;
   localparam int SMBUS_TMO_CYCLES = SMBUS_TMO_US * (CLK_HZ / 1_000_000);
   localparam int PWM_HZ = 33;
   localparam int PWM_SLOTS = 240;
   localparam int SLOT_CYCLES = CLK_HZ / (PWM_HZ * PWM_SLOTS);
   // arbitrary neutral bus address
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

   // ****************************************
   // carrier types
   // ****************************************
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
   } fpdc_reg_req_t;

   typedef enum logic [3:0] {
      BUS_IDLE, BUS_ADDR, BUS_ACK_ADDR, BUS_CMD, BUS_ACK_CMD,
      BUS_WDATA, BUS_ACK_WDATA, BUS_RDATA, BUS_ACK_RD
   } fpdc_bus_st_t;

endpackage

// File: hdl/fpdc_smbus_slave.sv
// two-wire management bus slave giving byte access to the register file
`timescale 1ns/1ps
module fpdc_smbus_slave import fpdc_pkg::*; #(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT,
   parameter int TMO_CYCLES = SMBUS_TMO_CYCLES
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe,
   input wire logic i_tmo_en,
   input wire logic [7:0] i_rdata,
   output fpdc_reg_req_t o_req
);
   localparam int TW = $clog2(TMO_CYCLES + 1);
   localparam logic [TW-1:0] TMO_LAST = TW'(TMO_CYCLES);

   typedef struct packed {
      fpdc_bus_st_t st;
      logic [7:0] sh;
      logic [3:0] cnt;
      logic [7:0] cmd;
      logic [7:0] wdata;
      logic rw;
      logic drive;
      logic wr;
      logic scl_q;
      logic sda_q;
      logic [TW-1:0] tmo;
   } fpdc_bus_state_t;

   fpdc_bus_state_t s_ff;
   fpdc_bus_state_t nxt_s;
   logic rise;
   logic fall;

   assign rise = i_scl & ~s_ff.scl_q;
   assign fall = ~i_scl & s_ff.scl_q;
   assign o_sda_out = 1'b0;
   assign o_sda_oe = s_ff.drive;
   assign o_req = '{wr: s_ff.wr, addr: s_ff.cmd, data: s_ff.wdata};

   always_comb begin
      nxt_s = s_ff;
      nxt_s.wr = 1'b0;
      nxt_s.scl_q = i_scl;
      nxt_s.sda_q = i_sda;
      // clock held low mid-transfer counts toward the timeout
      if (s_ff.st == BUS_IDLE || i_scl) begin
         nxt_s.tmo = '0;
      end else if (s_ff.tmo != TMO_LAST) begin
         nxt_s.tmo = s_ff.tmo + 1'b1;
      end
      if (i_scl && s_ff.scl_q && s_ff.sda_q && !i_sda) begin
         nxt_s.st = BUS_ADDR;
         nxt_s.cnt = 4'h0;
         nxt_s.drive = 1'b0;
      end else if (i_scl && s_ff.scl_q && !s_ff.sda_q && i_sda) begin
         nxt_s.st = BUS_IDLE;
         nxt_s.drive = 1'b0;
      end else if (i_tmo_en && s_ff.tmo == TMO_LAST) begin
         nxt_s.st = BUS_IDLE;
         nxt_s.drive = 1'b0;
      end else if (rise) begin
         if (s_ff.st == BUS_ADDR || s_ff.st == BUS_CMD || s_ff.st == BUS_WDATA) begin
            nxt_s.sh = {s_ff.sh[6:0], i_sda};
            nxt_s.cnt = s_ff.cnt + 4'h1;
         end
      end else if (fall) begin
         unique case (s_ff.st)
            BUS_ADDR: begin
               if (s_ff.cnt == 4'h8) begin
                  if (s_ff.sh[7:1] == DEV_ADDR) begin
                     nxt_s.st = BUS_ACK_ADDR;
                     nxt_s.rw = s_ff.sh[0];
                     nxt_s.drive = 1'b1;
                  end else begin
                     nxt_s.st = BUS_IDLE;
                  end
               end
            end
            BUS_ACK_ADDR: begin
               nxt_s.cnt = 4'h0;
               if (s_ff.rw) begin
                  nxt_s.st = BUS_RDATA;
                  nxt_s.sh = i_rdata;
                  nxt_s.drive = ~i_rdata[7];
               end else begin
                  nxt_s.st = BUS_CMD;
                  nxt_s.drive = 1'b0;
               end
            end
            BUS_CMD: begin
               if (s_ff.cnt == 4'h8) begin
                  nxt_s.cmd = s_ff.sh;
                  nxt_s.st = BUS_ACK_CMD;
                  nxt_s.drive = 1'b1;
               end
            end
            BUS_ACK_CMD: begin
               nxt_s.st = BUS_WDATA;
               nxt_s.cnt = 4'h0;
               nxt_s.drive = 1'b0;
            end
            BUS_WDATA: begin
               if (s_ff.cnt == 4'h8) begin
                  nxt_s.wdata = s_ff.sh;
                  nxt_s.wr = 1'b1;
                  nxt_s.st = BUS_ACK_WDATA;
                  nxt_s.drive = 1'b1;
               end
            end
            BUS_RDATA: begin
               if (s_ff.cnt == 4'h7) begin
                  nxt_s.st = BUS_ACK_RD;
                  nxt_s.drive = 1'b0;
               end else begin
                  nxt_s.sh = {s_ff.sh[6:0], 1'b0};
                  nxt_s.drive = ~s_ff.sh[6];
                  nxt_s.cnt = s_ff.cnt + 4'h1;
               end
            end
            BUS_ACK_WDATA, BUS_ACK_RD: begin
               // single byte per transfer; further bytes are not acknowledged
               nxt_s.st = BUS_IDLE;
               nxt_s.drive = 1'b0;
            end
            BUS_IDLE: begin
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         // idle pin levels, so no false edge follows reset
         s_ff <= '{st: BUS_IDLE, scl_q: 1'b1, sda_q: 1'b1, default: '0};
      end else begin
         s_ff <= nxt_s;
      end
   end

endmodule

// File: hdl/fpdc_fan_ctrl.sv
// two-fan duty controller: register file, temperature-to-duty law, ramp and pwm
`timescale 1ns/1ps
module fpdc_fan_ctrl import fpdc_pkg::*; #(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT,
   parameter int TMO_CYCLES = SMBUS_TMO_CYCLES,
   parameter int TICK_CYCLES = RAMP_TICK_CYCLES,
   parameter int SLOT_LEN = SLOT_CYCLES,
   parameter int SPIN_LEN = SPIN_TICKS
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe,
   input wire logic [7:0] i_chan1_temp,
   input wire logic [7:0] i_chan2_remote_temp,
   input wire logic [7:0] i_die_temp,
   output logic o_conv_halt,
   output logic o_fan1_drive_out,
   output logic o_fan1_drive_oe,
   output logic o_fan2_drive_out,
   output logic o_fan2_drive_oe
);
   localparam int KW = $clog2(TICK_CYCLES);
   localparam int PW = $clog2(SLOT_LEN + 1);
   localparam int SW = $clog2(SPIN_LEN + 1);
   localparam logic [KW-1:0] TICK_LAST = KW'(TICK_CYCLES - 1);
   localparam logic [PW-1:0] SLOT_LAST = PW'(SLOT_LEN - 1);
   localparam logic [SW-1:0] SPIN_LAST = SW'(SPIN_LEN - 1);
   localparam logic [7:0] SLOT_TOP = 8'(PWM_SLOTS - 1);

   typedef struct packed {
      logic [7:0] gcfg;
      logic [7:0] start_duty;
      logic [1:0][7:0] ceil;
      logic [1:0][7:0] goal;
      logic [1:0][7:0] pres;
      logic [1:0][7:0] start_t;
      logic [7:0] setup;
      logic [7:0] rate;
      logic [7:0] step;
      logic [1:0][7:0] eff_t;
      logic [KW-1:0] tick_cnt;
      logic tick;
      logic [1:0][5:0] rate_cnt;
      logic [1:0] spin;
      logic [1:0][SW-1:0] spin_cnt;
      logic [PW-1:0] slot_pre;
      logic [7:0] slot;
      logic [1:0] drv_oe;
   } fpdc_ctrl_state_t;

   function automatic fpdc_ctrl_state_t rst_state();
      fpdc_ctrl_state_t r;
      r = '0;
      r.gcfg = RST_GLOBAL;
      r.start_duty = RST_START_DUTY;
      r.ceil = {RST_CEIL, RST_CEIL};
      r.goal = {RST_GOAL, RST_GOAL};
      r.pres = {RST_PRES, RST_PRES};
      r.start_t = {RST_START_T, RST_START_T};
      r.setup = RST_SETUP;
      r.rate = RST_RATE;
      r.step = RST_STEP;
      return r;
   endfunction

   function automatic logic [7:0] clip_full(input logic [7:0] v);
      return (v > DUTY_FULL) ? DUTY_FULL : v;
   endfunction

   fpdc_ctrl_state_t s_ff;
   fpdc_ctrl_state_t nxt_s;
   fpdc_reg_req_t req;
   logic [7:0] rdata;
   logic [1:0][7:0] temp_in;
   logic [1:0][7:0] chan_duty;
   logic [7:0] start_duty_eff;

   // ****************************************
   // register bus
   // ****************************************
   fpdc_smbus_slave #(
      .DEV_ADDR(DEV_ADDR),
      .TMO_CYCLES(TMO_CYCLES)
   ) u_bus (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_scl(i_scl),
      .i_sda(i_sda),
      .o_sda_out(o_sda_out),
      .o_sda_oe(o_sda_oe),
      .i_tmo_en(~s_ff.gcfg[GC_TMO_OFF]),
      .i_rdata(rdata),
      .o_req(req)
   );

   always_comb begin
      unique case (req.addr)
         OFS_GLOBAL_CONFIG: rdata = s_ff.gcfg;
         OFS_START_DUTY: rdata = s_ff.start_duty;
         OFS_FAN1_CEIL: rdata = s_ff.ceil[0];
         OFS_FAN2_CEIL: rdata = s_ff.ceil[1];
         OFS_FAN1_GOAL: rdata = s_ff.goal[0];
         OFS_FAN2_GOAL: rdata = s_ff.goal[1];
         OFS_FAN1_PRES: rdata = s_ff.pres[0];
         OFS_FAN2_PRES: rdata = s_ff.pres[1];
         OFS_CHAN1_START_T: rdata = s_ff.start_t[0];
         OFS_CHAN2_START_T: rdata = s_ff.start_t[1];
         OFS_SETUP: rdata = s_ff.setup;
         OFS_RATE: rdata = s_ff.rate;
         OFS_STEP: rdata = s_ff.step;
         default: rdata = 8'h00;
      endcase
   end

   // ****************************************
   // per-channel temperature to duty law
   // ****************************************
   assign temp_in[0] = i_chan1_temp;
   assign temp_in[1] = s_ff.gcfg[GC_CH2_DIE] ? i_die_temp : i_chan2_remote_temp;
   assign start_duty_eff = clip_full(s_ff.start_duty);

   for (genvar c = 0; c < 2; c++) begin : g_chan
      logic [3:0] code;
      logic [4:0] per_step;
      logic [7:0] diff;
      logic [7:0] nsteps;
      logic [13:0] raw;
      logic [7:0] duty;
      assign code = (c == 0) ? s_ff.step[STEP_C1_LSB +: 4] : s_ff.step[STEP_C2_LSB +: 4];
      assign per_step = (code == STEP_CODE_TOP) ? STEP_TOP_DUTY : {code, 1'b0};
      assign diff = s_ff.eff_t[c] - s_ff.start_t[c];
      assign nsteps = s_ff.setup[FS_TSTEP] ? {1'b0, diff[7:1]} : diff;
      assign raw = {6'h00, start_duty_eff} + (14'(nsteps) * 14'(per_step));
      assign chan_duty[c] = duty;
      always_comb begin
         if (s_ff.eff_t[c] >= s_ff.start_t[c]) begin
            duty = (raw > 14'(DUTY_FULL)) ? DUTY_FULL : raw[7:0];
         end else if (s_ff.gcfg[GC_FLOOR]) begin
            duty = start_duty_eff;
         end else begin
            duty = 8'h00;
         end
      end
   end

   // ****************************************
   // state update
   // ****************************************
   always_comb begin
      logic [7:0] hyst;
      logic [7:0] ceil_eff;
      logic [7:0] pick;
      logic [7:0] tgt;
      logic [7:0] drv;
      logic [2:0] rcode;
      logic [6:0] rlim;
      logic sel1;
      logic sel2;
      hyst = 8'h00;
      ceil_eff = 8'h00;
      pick = 8'h00;
      tgt = 8'h00;
      drv = 8'h00;
      rcode = 3'h0;
      rlim = 7'h00;
      sel1 = 1'b0;
      sel2 = 1'b0;
      nxt_s = s_ff;

      if (req.wr) begin
         unique case (req.addr)
            OFS_GLOBAL_CONFIG: nxt_s.gcfg = req.data & ~(8'h01 << GC_SOFT_RST);
            OFS_START_DUTY: nxt_s.start_duty = req.data;
            OFS_FAN1_CEIL: nxt_s.ceil[0] = req.data;
            OFS_FAN2_CEIL: nxt_s.ceil[1] = req.data;
            OFS_FAN1_GOAL: nxt_s.goal[0] = req.data;
            OFS_FAN2_GOAL: nxt_s.goal[1] = req.data;
            OFS_CHAN1_START_T: nxt_s.start_t[0] = req.data;
            OFS_CHAN2_START_T: nxt_s.start_t[1] = req.data;
            OFS_SETUP: nxt_s.setup = req.data;
            OFS_RATE: nxt_s.rate = req.data;
            OFS_STEP: nxt_s.step = req.data;
            default: ;
         endcase
      end

      // shared 1/16 s ramp timebase
      nxt_s.tick = (s_ff.tick_cnt == TICK_LAST);
      nxt_s.tick_cnt = nxt_s.tick ? '0 : s_ff.tick_cnt + 1'b1;

      // hysteresis: follow rises at once, falls only once they reach the band
      hyst = s_ff.setup[FS_HYST] ? HYST_HI : HYST_LO;
      for (int c = 0; c < 2; c++) begin
         if (!s_ff.gcfg[GC_STANDBY]) begin
            if (temp_in[c] > s_ff.eff_t[c] || s_ff.eff_t[c] - temp_in[c] >= hyst) begin
               nxt_s.eff_t[c] = temp_in[c];
            end
         end
      end

      for (int f = 0; f < 2; f++) begin
         sel1 = s_ff.setup[(f == 0) ? FS_F1_C1 : FS_F2_C1];
         sel2 = s_ff.setup[(f == 0) ? FS_F1_C2 : FS_F2_C2];
         pick = 8'h00;
         if (sel1 && chan_duty[0] > pick) begin
            pick = chan_duty[0];
         end
         if (sel2 && chan_duty[1] > pick) begin
            pick = chan_duty[1];
         end
         ceil_eff = clip_full(s_ff.ceil[f]);
         if (ceil_eff < DUTY_CEIL_MIN) begin
            ceil_eff = DUTY_CEIL_MIN;
         end
         if (sel1 || sel2) begin
            tgt = (pick > ceil_eff) ? ceil_eff : pick;
            nxt_s.goal[f] = tgt;
         end else begin
            tgt = clip_full(s_ff.goal[f]);
         end

         rcode = s_ff.rate[(f == 0) ? RATE_F1_LSB : RATE_F2_LSB +: 3];
         rlim = 7'h01 << (rcode - 3'h1);
         if (s_ff.spin[f]) begin
            if (s_ff.tick) begin
               if (s_ff.spin_cnt[f] == SPIN_LAST) begin
                  nxt_s.spin[f] = 1'b0;
                  nxt_s.pres[f] = tgt;
               end else begin
                  nxt_s.spin_cnt[f] = s_ff.spin_cnt[f] + 1'b1;
               end
            end
         end else if (!s_ff.gcfg[GC_KICK_OFF] && s_ff.pres[f] == 8'h00
                      && tgt != 8'h00) begin
            nxt_s.spin[f] = 1'b1;
            nxt_s.spin_cnt[f] = '0;
            nxt_s.pres[f] = DUTY_FULL;
         end else if (rcode == 3'h0) begin
            nxt_s.pres[f] = tgt;
         end else if (s_ff.tick) begin
            if ({1'b0, s_ff.rate_cnt[f]} + 7'h01 >= rlim) begin
               nxt_s.rate_cnt[f] = 6'h00;
               if (tgt > s_ff.pres[f]) begin
                  nxt_s.pres[f] = (tgt - s_ff.pres[f] > RAMP_STEP) ?
                                  s_ff.pres[f] + RAMP_STEP : tgt;
               end else if (tgt < s_ff.pres[f]) begin
                  nxt_s.pres[f] = (s_ff.pres[f] - tgt > RAMP_STEP) ?
                                  s_ff.pres[f] - RAMP_STEP : tgt;
               end
            end else begin
               nxt_s.rate_cnt[f] = s_ff.rate_cnt[f] + 6'h01;
            end
         end
      end

      // ****************************************
      // pwm slots
      // ****************************************
      if (s_ff.slot_pre == SLOT_LAST) begin
         nxt_s.slot_pre = '0;
         nxt_s.slot = (s_ff.slot == SLOT_TOP) ? 8'h00 : s_ff.slot + 8'h01;
      end else begin
         nxt_s.slot_pre = s_ff.slot_pre + 1'b1;
      end
      for (int f = 0; f < 2; f++) begin
         drv = s_ff.pres[f];
         // open drain: polarity 1 releases the pin for active slots
         if (s_ff.gcfg[GC_STANDBY]) begin
            nxt_s.drv_oe[f] = 1'b0;
         end else if (s_ff.gcfg[(f == 0) ? GC_FAN1_POL : GC_FAN2_POL]) begin
            nxt_s.drv_oe[f] = !(s_ff.slot < drv);
         end else begin
            nxt_s.drv_oe[f] = (s_ff.slot < drv);
         end
      end

      if (req.wr && req.addr == OFS_GLOBAL_CONFIG && req.data[GC_SOFT_RST]) begin
         nxt_s = rst_state();
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_ff <= rst_state();
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign o_conv_halt = s_ff.gcfg[GC_STANDBY];
   assign o_fan1_drive_out = 1'b0;
   assign o_fan2_drive_out = 1'b0;
   assign o_fan1_drive_oe = s_ff.drv_oe[0];
   assign o_fan2_drive_oe = s_ff.drv_oe[1];

endmodule

// File: bench/fpdc_fan_ctrl_sva.sv
// port checker for the two-fan duty controller
`timescale 1ns/1ps
module fpdc_chk #(
   parameter int TMO_CYCLES = 250000
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_scl,
   input wire logic o_sda_out,
   input wire logic o_sda_oe,
   input wire logic o_conv_halt,
   input wire logic o_fan1_drive_out,
   input wire logic o_fan1_drive_oe,
   input wire logic o_fan2_drive_out,
   input wire logic o_fan2_drive_oe
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);
   // cycles the bus clock has been held low
   int lo_cnt;
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lo_cnt <= 0;
      end else begin
         lo_cnt <= i_scl ? 0 : lo_cnt + 1;
      end
   end
   chk_fan1_od_only: assert property (o_fan1_drive_out == 1'h0)
      else $error("fan1 pin driven high");
   chk_fan2_od_only: assert property (o_fan2_drive_out == 1'h0)
      else $error("fan2 pin driven high");
   chk_sda_od_only: assert property (o_sda_out == 1'h0)
      else $error("sda driven high");
   chk_halt_frees_f1: assert property (o_conv_halt && $past(o_conv_halt) |-> !o_fan1_drive_oe)
      else $error("fan1 held in standby");
   chk_halt_frees_f2: assert property (o_conv_halt && $past(o_conv_halt) |-> !o_fan2_drive_oe)
      else $error("fan2 held in standby");
   chk_halt_scl_low: assert property ($changed(o_conv_halt) |-> !i_scl)
      else $error("standby moved outside a write");
   chk_tmo_release: assert property (lo_cnt > TMO_CYCLES + 4 |-> !o_sda_oe)
      else $error("sda held past bus timeout");
   chk_sda_scl_high: assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe))
      else $error("sda moved while scl high");
endmodule
bind fpdc_fan_ctrl fpdc_chk #(.TMO_CYCLES(TMO_CYCLES)) fpdc_chk_inst (
   .i_core_clk(i_core_clk),
   .i_rst_n(i_rst_n),
   .i_scl(i_scl),
   .o_sda_out(o_sda_out),
   .o_sda_oe(o_sda_oe),
   .o_conv_halt(o_conv_halt),
   .o_fan1_drive_out(o_fan1_drive_out),
   .o_fan1_drive_oe(o_fan1_drive_oe),
   .o_fan2_drive_out(o_fan2_drive_out),
   .o_fan2_drive_oe(o_fan2_drive_oe)
);

// File: bench/fpdc_fan_model.sv
// fan model: pulled-up open-drain pin, high cycles counted per period
`timescale 1ns/1ps
module fpdc_fan_model #(
   parameter int PERIOD = 480
) (
   input wire logic i_core_clk,
   input wire logic i_oe,
   output logic [15:0] o_high_cnt
);
   int cyc = 0;
   int acc = 0;
   // a whole-period window makes the count phase independent
   always @(posedge i_core_clk) begin
      acc = acc + int'(!i_oe);
      cyc = cyc + 1;
      if (cyc == PERIOD) begin
         o_high_cnt <= 16'(acc);
         acc = 0;
         cyc = 0;
      end
   end
endmodule

// File: bench/tb_fpdc_fan_ctrl.sv
// self-checking bench for the two-fan duty controller
`timescale 1ns/1ps
module tb_fpdc_fan_ctrl import fpdc_pkg::*;;
   logic clk;
   logic rst_n;
   logic scl;
   logic sda_m;
   logic [7:0] t1;
   logic [7:0] t2;
   logic [7:0] td;
   logic [7:0] d;
   logic [15:0] h1;
   logic [15:0] h2;
   wire sda_oe;
   wire halt;
   wire f1oe;
   wire f2oe;
   wire sda_w = sda_m & ~sda_oe;
   int errors;
   int cmp_count;
   logic [7:0] ofs [11] = '{8'h02, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0F, 8'h11,
      8'h12, 8'h30};
   logic [7:0] rv [11] = '{8'h18, 8'h60, 8'hF0, 8'hF0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'hB4, 8'h00};
   fpdc_fan_ctrl #(.TMO_CYCLES(50), .TICK_CYCLES(20), .SLOT_LEN(2), .SPIN_LEN(2))
      fpdc_fan_ctrl_inst (.i_core_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda_w),
      .o_sda_out(), .o_sda_oe(sda_oe), .i_chan1_temp(t1), .i_chan2_remote_temp(t2),
      .i_die_temp(td), .o_conv_halt(halt), .o_fan1_drive_out(), .o_fan1_drive_oe(f1oe),
      .o_fan2_drive_out(), .o_fan2_drive_oe(f2oe));
   fpdc_fan_model #(.PERIOD(480)) fpdc_fan_model_inst (.i_core_clk(clk), .i_oe(f1oe),
      .o_high_cnt(h1));
   fpdc_fan_model #(.PERIOD(480)) fpdc_fan_model_inst_2 (.i_core_clk(clk), .i_oe(f2oe),
      .o_high_cnt(h2));
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic hp();
      repeat (4) @(negedge clk);
   endtask
   task automatic bw(input logic b);
      scl = 0;
      hp();
      sda_m = b;
      hp();
      scl = 1;
      hp();
   endtask
   task automatic br(output logic b);
      scl = 0;
      hp();
      sda_m = 1;
      hp();
      scl = 1;
      b = sda_w;
      hp();
   endtask
   // start and repeated start share one shape
   task automatic sta();
      bw(1'h1);
      sda_m = 0;
      hp();
   endtask
   task automatic stp();
      bw(1'h0);
      sda_m = 1;
      hp();
   endtask
   task automatic bytew(input logic [7:0] v);
      logic a;
      for (int i = 7; i >= 0; i--) bw(v[i]);
      br(a);
      chk("ack", 16'h0, 16'(a));
   endtask
   task automatic wr(input logic [7:0] o, input logic [7:0] v);
      sta();
      bytew({DEV_ADDR_DEFAULT, 1'h0});
      bytew(o);
      bytew(v);
      stp();
   endtask
   task automatic rd(input logic [7:0] o);
      sta();
      bytew({DEV_ADDR_DEFAULT, 1'h0});
      bytew(o);
      sta();
      bytew({DEV_ADDR_DEFAULT, 1'h1});
      for (int i = 7; i >= 0; i--) br(d[i]);
      bw(1'h1);
      stp();
   endtask
   task automatic rc(input logic [7:0] o, input logic [7:0] e);
      rd(o);
      chk($sformatf("reg %h", o), 16'(e), 16'(d));
   endtask
   task automatic pw(input logic [15:0] e, input logic [15:0] e2);
      repeat (1000) @(negedge clk);
      chk("fan1 high", e, h1);
      chk("fan2 high", e2, h2);
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      // tests take about 29k cycles; leave ample margin
      #(100 * 40000);
      errors++;
      test_done();
   end
   initial begin
      {rst_n, scl, sda_m, t1, t2, td, errors, cmp_count} = {3'h3, 8'd39, 8'd5, 8'h0, 64'h0};
      repeat (10) @(negedge clk);
      rst_n = 1;
      repeat (3) @(negedge clk);
      foreach (ofs[i]) rc(ofs[i], rv[i]);
      $display("test reset done");
      wr(8'h12, 8'h00);
      wr(8'h09, 8'h10);
      wr(8'h0B, 8'hFF);
      rc(8'h0D, 8'hF0);
      pw(16'd480, 16'd0);
      wr(8'h0B, 8'h30);
      wr(8'h02, 8'h08);
      pw(16'd384, 16'd0);
      rc(8'h0D, 8'h30);
      $display("test manual done");
      wr(8'h02, 8'h18);
      wr(8'h09, 8'hF0);
      wr(8'h0F, 8'd40);
      wr(8'h11, 8'h20);
      rc(8'h0B, 8'h00);
      t1 = 8'd40;
      rc(8'h0B, 8'h60);
      t1 = 8'd42;
      rc(8'h0B, 8'h74);
      t1 = 8'd39;
      rc(8'h0B, 8'h74);
      t1 = 8'd37;
      rc(8'h0B, 8'h00);
      wr(8'h02, 8'h1C);
      t1 = 8'd30;
      rc(8'h0B, 8'h60);
      t1 = 8'd44;
      wr(8'h11, 8'h60);
      rc(8'h0B, 8'h74);
      wr(8'h09, 8'h50);
      rc(8'h0B, 8'h50);
      wr(8'h09, 8'h01);
      rc(8'h0B, 8'h02);
      wr(8'h09, 8'hF0);
      wr(8'h11, 8'h30);
      rc(8'h0B, 8'h92);
      wr(8'h02, 8'h1E);
      rc(8'h0B, 8'h88);
      $display("test auto done");
      wr(8'h02, 8'h1F);
      wr(8'h12, 8'h04);
      wr(8'h0C, 8'hF0);
      rd(8'h0E);
      chk("ramp part", 16'h1, 16'(d > 0 && d < 8'hF0 && !d[0]));
      repeat (3000) @(negedge clk);
      rc(8'h0E, 8'hF0);
      pw(16'd272, 16'd480);
      $display("test ramp done");
      wr(8'h02, 8'h9F);
      chk("halt", 16'h1, 16'(halt));
      pw(16'd480, 16'd480);
      wr(8'h02, 8'h40);
      chk("halt", 16'h0, 16'(halt));
      rc(8'h02, 8'h18);
      rc(8'h12, 8'hB4);
      rc(8'h11, 8'h00);
      $display("test standby done");
      sta();
      for (int i = 7; i >= 1; i--) bw(DEV_ADDR_DEFAULT[i - 1]);
      bw(1'h0);
      scl = 0;
      repeat (3) @(negedge clk);
      chk("ack", 16'h1, 16'(sda_oe));
      repeat (60) @(negedge clk);
      chk("timeout", 16'h0, 16'(sda_oe));
      stp();
      $display("test timeout done");
      test_done();
   end
endmodule
